// *** tb_windowed_watchdog_with_deep_sleep_timer.sv ***
`timescale 1ns/1ps
module tb_windowed_watchdog_with_deep_sleep_timer;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, dsel, wake_ev;
   logic        wdog_reset_req, wake_req, deep_wake_req, core_halted, low_power_rc_osc_enable;
   logic        secondary_crystal_osc_enable, wdog_clear_instr, power_save_instr, clock_switch_done;
   logic [1:0]  halt_mode;
   logic [2:0]  osc_div, evs;
   logic [7:0]  paddr, wcfg, dcfg;
   logic [31:0] pwdata, prdata, rd;
   int          fails, total_checks, cycles, seed, rst_seen, got, snap;
   assign evs = {deep_wake_req, wake_req, wdog_reset_req};
   wdsl_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .low_power_rc_osc(osc_div[1]), .secondary_crystal_osc(osc_div[2]),
      .wdog_config_byte(wcfg), .deep_sleep_config_byte(dcfg),
      .wdog_clear_instr(wdog_clear_instr), .power_save_instr(power_save_instr),
      .halt_mode(halt_mode), .clock_switch_done(clock_switch_done), .wake_event(wake_ev),
      .wdog_reset_req(wdog_reset_req), .wake_req(wake_req), .deep_wake_req(deep_wake_req),
      .core_halted(core_halted), .low_power_rc_osc_enable(low_power_rc_osc_enable), .secondary_crystal_osc_enable(secondary_crystal_osc_enable));
   wdsl_core_model core (.pclk(pclk), .wdog_clear_instr(wdog_clear_instr),
      .power_save_instr(power_save_instr), .halt_mode(halt_mode),
      .clock_switch_done(clock_switch_done));
   // ----------------------------------------
   // Clocks, oscillator pins and run limit
   // ----------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      osc_div <= osc_div + 3'h1;
      cycles  <= cycles + 1;
      if (wdog_reset_req === 1'b1)
         rst_seen <= rst_seen + 1;
      if (cycles == 40000)
      begin
         fails++;
         end_sim();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic near(input string name, input int exp, input int seen);
      total_checks++;
      if (seen < exp - 12 || seen > exp + 12)
      begin
         fails++;
         $display("wrong value %s expected %0d seen %0d", name, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk("access_cycles", 32'h1, n);
   endtask
   // Cycles until the chosen event output is seen, or limit
   task automatic meas(input int which, input int limit, output int n);
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (evs[which] !== 1'b1 && n < limit);
   endtask
   task automatic do_reset(input logic [7:0] wc, input logic [7:0] dc);
      presetn <= 1'b0;
      wcfg    <= wc;
      dcfg    <= dc;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      seed = 32'h6d92;
      {psel, penable, pwrite, presetn, wake_ev, osc_div, paddr, pwdata, wcfg, dcfg} = '0;
      do_reset(8'h40, 8'h00);
      apb(1'b0, 8'h00, 32'h0);
      chk("reset_control", 32'h0, rd);
      apb(1'b0, 8'h08, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, er});
      chk("unmapped_data", 32'h0, rd);
      meas(0, 300, got);
      chk("off_no_reset", 32'd300, got);
      apb(1'b1, 8'h00, 32'h20);
      apb(1'b0, 8'h00, 32'h0);
      chk("soft_enable", 32'h20, rd);
      core.pulse(0, 2'h0);
      meas(0, 400, got);
      near("soft_period", 128, got);
      apb(1'b0, 8'h00, 32'h0);
      chk("timeout_flag", 32'h30, rd);
      apb(1'b0, 8'h00, 32'h0);
      chk("flag_sticky", 32'h30, rd);
      apb(1'b1, 8'h00, 32'h20);
      apb(1'b0, 8'h00, 32'h0);
      chk("flag_cleared", 32'h20, rd);
      for (int i = 0; i < 4; i++)
      begin
         do_reset({3'b110, i[0], 2'b00, 2'($random(seed))}, 8'h00);
         core.pulse(0, 2'h0);
         meas(0, 5000, got);
         near("main_period", 4 << ((wcfg[4] ? 7 : 5) + wcfg[3:0]), got);
      end
      do_reset(8'hC3, 8'h00);
      for (int k = 0; k < 3; k++)
      begin
         repeat (60 + ($random(seed) & 31)) @(posedge pclk);
         core.pulse(k, 2'h1);
         apb(1'b0, 8'h04, 32'h0);
         chk("count_zeroed", 32'h1, {31'h0, rd <= 32'h2});
      end
      do_reset(8'h80, 8'h00);
      repeat (40) @(posedge pclk);
      core.pulse(0, 2'h0);
      meas(0, 3, got);
      chk("early_clear", 32'h1, {31'h0, wdog_reset_req});
      do_reset(8'h80, 8'h00);
      repeat (110) @(posedge pclk);
      core.pulse(0, 2'h0);
      meas(0, 400, got);
      near("late_clear", 128, got);
      for (int m = 1; m < 3; m++)
      begin
         do_reset(8'hC0, 8'h00);
         snap = rst_seen;
         core.pulse(2, 2'(m));
         repeat (2) @(posedge pclk);
         chk("core_halted", 32'h1, {31'h0, core_halted});
         meas(1, 400, got);
         near("halt_wake", 126, got);
         chk("halt_no_reset", snap, rst_seen);
         repeat (2) @(posedge pclk);
         chk("core_running", 32'h0, {31'h0, core_halted});
         apb(1'b0, 8'h00, 32'h0);
         chk("halt_status", 32'h1 << (m + 1), rd);
         apb(1'b1, 8'h00, 32'h0);
         apb(1'b0, 8'h00, 32'h0);
         chk("status_cleared", 32'h0, rd);
      end
      core.pulse(2, 2'h1);
      repeat (20) @(posedge pclk);
      wake_ev <= 1'b1;
      @(posedge pclk);
      wake_ev <= 1'b0;
      meas(1, 8, got);
      chk("wake_source", 32'h1, {31'h0, wake_req});
      for (int j = 0; j < 3; j++)
      begin
         dsel = (j != 1);
         do_reset(8'h00, {3'b100, dsel, 3'b000, j == 2});
         chk("rc_enable", {31'h0, dsel}, {31'h0, low_power_rc_osc_enable});
         chk("crystal_enable", {31'h0, !dsel}, {31'h0, secondary_crystal_osc_enable});
         core.pulse(2, 2'h3);
         meas(2, 5000, got);
         near("deep_period", (dsel ? 4 : 8) << (6 + 2 * (j == 2)), got);
      end
      end_sim();
   end
endmodule

// *** wdsl_core_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Core model: instruction pulses
// ----------------------------------------
module wdsl_core_model (
   input  wire logic  pclk,
   output logic       wdog_clear_instr,
   output logic       power_save_instr,
   output logic [1:0] halt_mode,
   output logic       clock_switch_done
);
   initial
   begin
      wdog_clear_instr  = 1'b0;
      power_save_instr  = 1'b0;
      halt_mode         = 2'h0;
      clock_switch_done = 1'b0;
   end
   // One-cycle pulse: kind 0 clear, 1 clock switch, 2 power save
   task automatic pulse(input int kind, input logic [1:0] mode);
      @(posedge pclk);
      wdog_clear_instr  <= (kind == 0);
      clock_switch_done <= (kind == 1);
      power_save_instr  <= (kind == 2);
      halt_mode         <= mode;
      @(posedge pclk);
      wdog_clear_instr  <= 1'b0;
      clock_switch_done <= 1'b0;
      power_save_instr  <= 1'b0;
      halt_mode         <= ~mode;
   endtask
endmodule

// *** wdsl_pkg.sv ***
// How it works
// R1 - Enabled main watchdog keeps counting in light and deep-core halt states
// R2 - Main time-out while halted wakes the core, no reset
// R3 - Software clears the halt entry status bits after wake-up
// R4 - Time-out flag stays set until software writes it clear
// R5 - Clear and power-save instructions zero prescaler and postscaler counts
// R6 - Windowed mode: clear restarts count only in final quarter of period
// R7 - Windowed mode: early clear causes a watchdog reset like a time-out
// R8 - Windowed mode active when window-disable config bit 6 is zero
// R9 - Hardware enable config bit set: watchdog always runs (here it stops counting while in PS_DEEP deep sleep)
// R10 - Hardware enable clear: watchdog runs only while software enable bit 5 set
// R11 - Every device reset clears the software enable bit
// R12 - Deep-sleep watchdog counts in deep sleep from clock chosen by bit 4
// R13 - Four-bit field selects deep-sleep time-out, 2.1 ms to 25.7 days
// R14 - Enabling deep-sleep watchdog switches on its selected clock source
// R15 - Deep-sleep time-out wakes the device from deep sleep
// R16 - Main prescaler divides RC clock by 32 or 128
// R17 - Four-bit field selects main postscaler 1:1 to 1:32768
// R18 - Main counts reset on reset, clock switch, halt entry and exit, clear
// R19 - Deep-sleep prescaler 32, postscaler 1:2 at code 0 to 1:2^31
// R20 - Main time-out while running resets the device and sets the flag
// R21 - Window compares combined count; opens at three quarters of period
package wdsl_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] RESET_CONTROL_OFF = 8'h00;
   localparam logic [7:0] COUNT_STATUS_OFF  = 8'h04;
   localparam int RC_SOFT_EN_BIT  = 5;
   localparam int RC_TMO_FLAG_BIT = 4;
   localparam int RC_SLEEP_BIT    = 3;
   localparam int RC_IDLE_BIT     = 2;
   localparam logic [31:0] RESET_CONTROL_RST = 32'h0000_0000;
   // ----------------------------------------
   // Configuration byte fields
   // ----------------------------------------
   localparam int WCFG_HW_EN_BIT   = 7;
   localparam int WCFG_WIN_DIS_BIT = 6;
   localparam int WCFG_PRE_BIT     = 4;
   localparam int DCFG_EN_BIT      = 7;
   localparam int DCFG_CLK_SEL_BIT = 4;
   // ----------------------------------------
   // Divider exponents
   // ----------------------------------------
   localparam int MAIN_PRE_SHORT_EXP = 5;
   localparam int MAIN_PRE_LONG_EXP  = 7;
   localparam int DEEP_PRE_EXP       = 5;
   localparam int DEEP_POST_BASE_EXP = 1;
   localparam int MAIN_CNT_W = 22;
   localparam int DEEP_CNT_W = 36;
   // ----------------------------------------
   // Power states and halt requests
   // ----------------------------------------
   typedef enum logic [1:0] {
      PS_RUN  = 2'b00,
      PS_HALT = 2'b01,
      PS_DEEP = 2'b11
   } wdsl_pstate_t;
   localparam logic [1:0] HALT_IDLE  = 2'h1;
   localparam logic [1:0] HALT_SLEEP = 2'h2;
   localparam logic [1:0] HALT_DEEP  = 2'h3;
endpackage

// *** wdsl_top.sv ***
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
module wdsl_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        low_power_rc_osc,
   input  wire logic        secondary_crystal_osc,
   input  wire logic [7:0]  wdog_config_byte,
   input  wire logic [7:0]  deep_sleep_config_byte,
   input  wire logic        wdog_clear_instr,
   input  wire logic        power_save_instr,
   input  wire logic [1:0]  halt_mode,
   input  wire logic        clock_switch_done,
   input  wire logic        wake_event,
   output logic             wdog_reset_req,
   output logic             wake_req,
   output logic             deep_wake_req,
   output logic             core_halted,
   output logic             low_power_rc_osc_enable,
   output logic             secondary_crystal_osc_enable
);
   // ----------------------------------------
   // Divider helpers
   // ----------------------------------------
   function automatic logic [4:0] main_exp(input logic [7:0] cfg);
      logic [4:0] e;
      e = cfg[wdsl_pkg::WCFG_PRE_BIT] ? 5'(wdsl_pkg::MAIN_PRE_LONG_EXP)
                                      : 5'(wdsl_pkg::MAIN_PRE_SHORT_EXP);
      return 5'(e + {1'b0, cfg[3:0]});
   endfunction

   // ----------------------------------------
   // Clock pin synchronisers and edge detect
   // ----------------------------------------
   logic [1:0] s1_q, s2_q, s3_q;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         s1_q <= 2'h0;
         s2_q <= 2'h0;
         s3_q <= 2'h0;
      end
      else
      begin
         s1_q <= {secondary_crystal_osc, low_power_rc_osc};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   logic low_power_rc_osc_tick, secondary_crystal_osc_tick;
   assign low_power_rc_osc_tick = s2_q[0] & ~s3_q[0];
   assign secondary_crystal_osc_tick = s2_q[1] & ~s3_q[1];

   // ----------------------------------------
   // Control decode
   // ----------------------------------------
   wdsl_pkg::wdsl_pstate_t st_q;
   logic [wdsl_pkg::MAIN_CNT_W-1:0] main_cnt_q, main_mask;
   logic [wdsl_pkg::DEEP_CNT_W-1:0] deep_cnt_q, deep_mask;
   logic [4:0] mexp;
   logic [5:0] dexp;
   logic soft_en_q, flag_q, sleep_q, idle_q;
   logic main_run, windowed, win_open, early_clr, main_tmo, restart;
   logic deep_en, deep_sel_low_power_rc_osc, deep_tick, deep_tmo, halt_exit;
   assign mexp = main_exp(wdog_config_byte);                             // R16 R17
   assign main_mask = wdsl_pkg::MAIN_CNT_W'((23'h1 << mexp) - 23'h1);
   assign main_run = (wdog_config_byte[wdsl_pkg::WCFG_HW_EN_BIT] | soft_en_q) // R9 R10
                     & (st_q != wdsl_pkg::PS_DEEP);                       // R1
   assign windowed = ~wdog_config_byte[wdsl_pkg::WCFG_WIN_DIS_BIT];       // R8
   assign win_open = main_cnt_q[mexp - 5'h1] & main_cnt_q[mexp - 5'h2];   // R21
   assign early_clr = wdog_clear_instr & windowed & main_run & ~win_open  // R7
                      & (st_q == wdsl_pkg::PS_RUN);
   assign main_tmo = main_run & low_power_rc_osc_tick & (main_cnt_q == main_mask) & ~wdog_clear_instr; // R6
   assign halt_exit = (st_q == wdsl_pkg::PS_HALT) & (main_tmo | wake_event);
   assign restart = ~main_run | (wdog_clear_instr & ~early_clr)          // R5 R6
                    | early_clr | power_save_instr | clock_switch_done | halt_exit; // R18
   assign deep_en = deep_sleep_config_byte[wdsl_pkg::DCFG_EN_BIT];
   assign deep_sel_low_power_rc_osc = deep_sleep_config_byte[wdsl_pkg::DCFG_CLK_SEL_BIT]; // R12
   assign deep_tick = deep_sel_low_power_rc_osc ? low_power_rc_osc_tick : secondary_crystal_osc_tick;
   assign dexp = 6'(wdsl_pkg::DEEP_PRE_EXP + wdsl_pkg::DEEP_POST_BASE_EXP) // R19
                 + {1'b0, deep_sleep_config_byte[3:0], 1'b0};             // R13
   assign deep_mask = wdsl_pkg::DEEP_CNT_W'((37'h1 << dexp) - 37'h1);
   assign deep_tmo = deep_en & (st_q == wdsl_pkg::PS_DEEP) & deep_tick
                     & (deep_cnt_q == deep_mask);

   // ----------------------------------------
   // Main counter, prescaler and postscaler combined
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         main_cnt_q <= '0;                                                // R18
      else if (restart)
         main_cnt_q <= '0;
      else if (low_power_rc_osc_tick)
         main_cnt_q <= main_tmo ? '0 : main_cnt_q + 1'b1;                 // R1

   // ----------------------------------------
   // Deep-sleep counter
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         deep_cnt_q <= '0;
      else if (!deep_en || st_q != wdsl_pkg::PS_DEEP || deep_tmo)
         deep_cnt_q <= '0;
      else if (deep_tick)
         deep_cnt_q <= deep_cnt_q + 1'b1;                                 // R12

   // ----------------------------------------
   // Power state
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         st_q <= wdsl_pkg::PS_RUN;
      else
         case (st_q)
            wdsl_pkg::PS_RUN:
               if (power_save_instr)
                  st_q <= (halt_mode == wdsl_pkg::HALT_DEEP) ? wdsl_pkg::PS_DEEP
                                                             : wdsl_pkg::PS_HALT;
            wdsl_pkg::PS_HALT:
               if (halt_exit)
                  st_q <= wdsl_pkg::PS_RUN;                               // R2
            wdsl_pkg::PS_DEEP:
               if (deep_tmo || wake_event)
                  st_q <= wdsl_pkg::PS_RUN;                               // R15
            default:
               st_q <= wdsl_pkg::PS_RUN;
         endcase

   // ----------------------------------------
   // Event outputs and clock enables
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         wdog_reset_req <= 1'b0;
         wake_req       <= 1'b0;
         deep_wake_req  <= 1'b0;
         core_halted    <= 1'b0;
         low_power_rc_osc_enable    <= 1'b0;
         secondary_crystal_osc_enable    <= 1'b0;
      end
      else
      begin
         wdog_reset_req <= early_clr | (main_tmo & (st_q == wdsl_pkg::PS_RUN)); // R20 R7
         wake_req       <= halt_exit;                                     // R2
         deep_wake_req  <= deep_tmo;                                      // R15
         core_halted    <= st_q != wdsl_pkg::PS_RUN;
         low_power_rc_osc_enable    <= main_run | (deep_en & deep_sel_low_power_rc_osc);          // R14
         secondary_crystal_osc_enable    <= deep_en & ~deep_sel_low_power_rc_osc;                      // R14
      end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   logic setup, wr_ctrl, hit_ctrl, hit_cnt;
   assign setup = psel & ~penable;
   assign hit_ctrl = paddr == wdsl_pkg::RESET_CONTROL_OFF;
   assign hit_cnt = paddr == wdsl_pkg::COUNT_STATUS_OFF;
   assign wr_ctrl = psel & penable & pready & pwrite & hit_ctrl;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~hit_ctrl & ~hit_cnt;
         if (setup && !pwrite && hit_ctrl)
         begin
            prdata <= 32'h0000_0000;
            prdata[wdsl_pkg::RC_SOFT_EN_BIT]  <= soft_en_q;
            prdata[wdsl_pkg::RC_TMO_FLAG_BIT] <= flag_q;
            prdata[wdsl_pkg::RC_SLEEP_BIT]    <= sleep_q;
            prdata[wdsl_pkg::RC_IDLE_BIT]     <= idle_q;
         end
         else if (setup && !pwrite && hit_cnt)
            prdata <= 32'(main_cnt_q);
         else
            prdata <= 32'h0000_0000;
      end

   // ----------------------------------------
   // Reset control register bits
   // ----------------------------------------
   logic flag_set, sleep_set, idle_set;
   assign flag_set = wdog_reset_req;
   assign sleep_set = power_save_instr & (st_q == wdsl_pkg::PS_RUN)
                      & (halt_mode != wdsl_pkg::HALT_IDLE);
   assign idle_set = power_save_instr & (st_q == wdsl_pkg::PS_RUN)
                     & (halt_mode == wdsl_pkg::HALT_IDLE);
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         soft_en_q <= wdsl_pkg::RESET_CONTROL_RST[wdsl_pkg::RC_SOFT_EN_BIT]; // R11
         flag_q    <= wdsl_pkg::RESET_CONTROL_RST[wdsl_pkg::RC_TMO_FLAG_BIT];
         sleep_q   <= wdsl_pkg::RESET_CONTROL_RST[wdsl_pkg::RC_SLEEP_BIT];
         idle_q    <= wdsl_pkg::RESET_CONTROL_RST[wdsl_pkg::RC_IDLE_BIT];
      end
      else
      begin
         if (wr_ctrl)
            soft_en_q <= pwdata[wdsl_pkg::RC_SOFT_EN_BIT];                // R10
         flag_q  <= flag_set | (flag_q & ~(wr_ctrl & ~pwdata[wdsl_pkg::RC_TMO_FLAG_BIT])); // R4
         sleep_q <= sleep_set | (sleep_q & ~(wr_ctrl & ~pwdata[wdsl_pkg::RC_SLEEP_BIT])); // R3
         idle_q  <= idle_set | (idle_q & ~(wr_ctrl & ~pwdata[wdsl_pkg::RC_IDLE_BIT]));
      end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_run_tmo_reset: assert property (main_tmo && st_q == wdsl_pkg::PS_RUN // R20
      |=> wdog_reset_req ##1 flag_q) else $error("run time-out without reset");
   a_halt_tmo_wake: assert property (main_tmo && st_q == wdsl_pkg::PS_HALT // R2
      |=> wake_req && !wdog_reset_req && st_q == wdsl_pkg::PS_RUN)
      else $error("halt time-out did not wake");
   a_clear_zeroes: assert property ((wdog_clear_instr || power_save_instr) // R5
      |=> main_cnt_q == '0) else $error("clear left count");
   a_early_clear: assert property (wdog_clear_instr && windowed && main_run // R7
      && st_q == wdsl_pkg::PS_RUN && !win_open |=> wdog_reset_req)
      else $error("early clear not punished");
   a_late_clear: assert property (wdog_clear_instr && win_open && main_run // R6
      |=> !wdog_reset_req && main_cnt_q == '0) else $error("window clear failed");
   a_flag_sticky: assert property (flag_q && !wr_ctrl |=> flag_q) // R4
      else $error("flag dropped");
   a_hw_enable: assert property (wdog_config_byte[wdsl_pkg::WCFG_HW_EN_BIT] // R9
      && st_q != wdsl_pkg::PS_DEEP |-> main_run) else $error("hw enable ignored");
   a_soft_off: assert property (!wdog_config_byte[wdsl_pkg::WCFG_HW_EN_BIT] // R10
      && !soft_en_q |=> main_cnt_q == '0) else $error("counting while off");
   a_halt_count: assert property (st_q == wdsl_pkg::PS_HALT && main_run // R1
      && low_power_rc_osc_tick && !restart && !main_tmo |=> main_cnt_q == $past(main_cnt_q) + 1'b1)
      else $error("no count in halt");
   a_deep_clock: assert property (deep_en ##1 deep_en |=> // R14
      (deep_sel_low_power_rc_osc ? low_power_rc_osc_enable : secondary_crystal_osc_enable)) else $error("clock off");
   a_deep_wake: assert property (deep_tmo |=> deep_wake_req // R15
      && st_q == wdsl_pkg::PS_RUN) else $error("deep time-out lost");

   c_run_reset: cover property (main_tmo && st_q == wdsl_pkg::PS_RUN);
   c_halt_wake: cover property (st_q == wdsl_pkg::PS_HALT ##[1:50] wake_req);
   c_early_clr: cover property (early_clr);
   c_deep_wake: cover property (deep_wake_req);
endmodule
